// >>> common/icfm_pkg.sv
// package: register map, reset values, timing constants and carrier types of the clock frequency monitor
package icfm_pkg;

  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_LINK_SETUP    = 8'h5b;
  localparam logic [7:0] ADDR_LINK_CLK_OVR  = 8'h5c;
  localparam logic [7:0] ADDR_LOW_THRESH    = 8'h5d;
  localparam logic [7:0] ADDR_HIGH_THRESH   = 8'h5e;
  localparam logic [7:0] ADDR_MEASURED_FREQ = 8'h5f;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int BIT_LINK_SWAP_STATE   = 6;
  localparam int BIT_PLL_RESET_ON_CHG  = 5;
  localparam int BIT_MEASURE_SRC_SEL   = 4;
  localparam int BIT_INHIBIT_AUTO_SWAP = 7;
  localparam int BIT_OVERRIDE_LINK_RDY = 6;
  localparam int BIT_OVERRIDE_CLK_PRES = 5;
  localparam int POS_STBL_SEL          = 3;
  localparam int POS_HYST              = 0;
  localparam int BIT_PHY_RESET_POLICY  = 6;
  localparam int POS_LOW_LIMIT         = 0;
  localparam int POS_HIGH_LIMIT        = 0;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic       RST_LINK_SWAP_STATE  = 1'b0;
  localparam logic       RST_PLL_RESET_ON_CHG = 1'b1;
  localparam logic       RST_MEASURE_SRC_SEL  = 1'b0;
  localparam logic       RST_INHIBIT_SWAP     = 1'b0;
  localparam logic       RST_OVERRIDE_LINK    = 1'b0;
  localparam logic       RST_OVERRIDE_CLK     = 1'b0;
  localparam logic [1:0] RST_STBL_SEL         = 2'h0;
  localparam logic [2:0] RST_HYST_MHZ         = 3'h2;
  localparam logic       RST_PHY_POLICY       = 1'b0;
  localparam logic [5:0] RST_LOW_LIMIT        = 6'h06;
  localparam logic [6:0] RST_HIGH_LIMIT       = 7'h2c;
  localparam logic [7:0] RST_MEASURED_FREQ    = 8'h00;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 10;
  localparam int GATE_TIME_NS    = 1000;
  localparam int GATE_CYCLES     = GATE_TIME_NS / CLK_PERIOD_NS;
  localparam int STBL_TIME_0_US  = 160;
  localparam int STBL_TIME_1_US  = 640;
  localparam int STBL_TIME_2_US  = 1280;
  localparam int STBL_TIME_3_US  = 2550;
  localparam int GATE_TIME_US    = GATE_TIME_NS / 1000;
  localparam int STBL_CNT_W      = 12;

  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic       inhibit_auto_swap;
    logic       override_link_ready;
    logic       override_clock_present;
    logic [1:0] stability_time_select;
    logic [2:0] measure_hysteresis_mhz;
    logic       phy_reset_policy;
    logic [5:0] low_freq_limit;
    logic [6:0] high_freq_limit;
    logic       pll_reset_on_change;
    logic       measure_source_select;
  } icfm_cfg_t;

  typedef struct packed {
    logic       done;
    logic [7:0] mhz;
  } icfm_meas_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SETTLING,
    ST_STABLE
  } icfm_state_t;

endpackage

// >>> rtl/icfm_freq_meter.sv
// module: counts rising edges of the selected input clock over a one-microsecond gate
module icfm_freq_meter (
  // clock and reset
  input  wire logic                i_ref_clk,
  input  wire logic                i_rst,
  // measured clocks, asynchronous to i_ref_clk
  input  wire logic                i_raw_clk,
  input  wire logic                i_pll_clk,
  // control
  input  wire logic                i_source_sel,
  input  wire logic                i_gate_tick,
  // result
  output icfm_pkg::icfm_meas_t     o_meas
);

  // ------------------------------------------------------------
  // synchronisers and edge detect
  // ------------------------------------------------------------
  logic [1:0] sync1_q;
  logic [1:0] sync2_q;
  logic [1:0] sync3_q;
  logic [1:0] edge_hit;
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  icfm_pkg::icfm_meas_t meas_q;
  icfm_pkg::icfm_meas_t meas_d;

  // only the second and third stages feed the edge detector
  assign edge_hit = sync2_q & ~sync3_q;

  // ------------------------------------------------------------
  // edge counter
  // ------------------------------------------------------------
  always_comb begin
    cnt_d  = cnt_q;
    meas_d = meas_q;
    meas_d.done = 1'b0;
    if (edge_hit[i_source_sel] && (cnt_q != 8'hff)) begin
      cnt_d = cnt_q + 8'h01;
    end
    if (i_gate_tick) begin
      // edges per microsecond is the frequency in MHz
      meas_d.mhz  = cnt_q;
      meas_d.done = 1'b1;
      cnt_d       = 8'h00;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      sync1_q <= 2'h0;
      sync2_q <= 2'h0;
      sync3_q <= 2'h0;
      cnt_q   <= 8'h00;
      meas_q  <= '0;
    end else begin
      sync1_q <= {i_pll_clk, i_raw_clk};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      cnt_q   <= cnt_d;
      meas_q  <= meas_d;
    end
  end

  assign o_meas = meas_q;

endmodule

// >>> rtl/icfm_top.sv
// module: input clock frequency monitor with hysteresis, stability timer, limits and link overrides

module icfm_top (
  // clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst,
  // register port
  input  wire logic [7:0] i_reg_addr,
  input  wire logic       i_reg_wr_en,
  input  wire logic [7:0] i_reg_wdata,
  output logic      [7:0] o_reg_rdata,
  // measured clocks and pins, asynchronous
  input  wire logic       i_hdmi_clk,
  input  wire logic       i_hdmi_pll_clk,
  input  wire logic       i_hdmi_5v_det,
  input  wire logic       i_rx_signal_valid,
  input  wire logic       i_backchannel_link_ok,
  // device logic, same clock
  input  wire logic       i_mode_change,
  input  wire logic       i_swap_detected,
  // status and control outputs
  output logic            o_clock_present,
  output logic            o_freq_too_low,
  output logic            o_freq_too_high,
  output logic            o_freq_settled,
  output logic            o_link_ready,
  output logic            o_link_swap_state,
  output logic            o_pll_reset,
  output logic            o_phy_reset
);

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  icfm_pkg::icfm_cfg_t   cfg_q;
  icfm_pkg::icfm_cfg_t   cfg_d;
  icfm_pkg::icfm_meas_t  meas;
  icfm_pkg::icfm_state_t state_q;
  icfm_pkg::icfm_state_t state_d;
  logic       swap_q;
  logic       swap_d;
  logic [6:0] gate_cnt_q;
  logic [6:0] gate_cnt_d;
  logic       gate_tick_q;
  logic       gate_tick_d;
  logic [7:0] stored_q;
  logic [7:0] stored_d;
  logic [11:0] stbl_cnt_q;
  logic [11:0] stbl_cnt_d;
  logic [11:0] stbl_target;
  logic [7:0] diff;
  logic       capture;
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic       det_5v;
  logic       rx_valid;
  logic       bc_link_ok;
  logic       too_low;
  logic       too_high;
  logic       present_d;
  logic [7:0] rdata_d;
  logic [7:0] meas_read;
  logic       o_clock_present_q;
  logic       o_freq_too_low_q;
  logic       o_freq_too_high_q;
  logic       o_link_ready_q;
  logic       o_pll_reset_q;
  logic       o_phy_reset_q;
  logic       o_pll_reset_d;
  logic       o_phy_reset_d;
  logic [7:0] o_reg_rdata_q;
  logic       settled_q;

  localparam logic [6:0] GATE_LAST = 7'(icfm_pkg::GATE_CYCLES - 1);

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
    end else begin
      sync1_q <= {i_backchannel_link_ok, i_rx_signal_valid, i_hdmi_5v_det};
      sync2_q <= sync1_q;
    end
  end

  assign det_5v     = sync2_q[0];
  assign rx_valid   = sync2_q[1];
  assign bc_link_ok = sync2_q[2];

  // ------------------------------------------------------------
  // one-microsecond gate divider
  // ------------------------------------------------------------
  always_comb begin
    gate_tick_d = (gate_cnt_q == GATE_LAST);
    gate_cnt_d  = gate_tick_d ? 7'h00 : gate_cnt_q + 7'h01;
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      gate_cnt_q  <= 7'h00;
      gate_tick_q <= 1'b0;
    end else begin
      gate_cnt_q  <= gate_cnt_d;
      gate_tick_q <= gate_tick_d;
    end
  end

  icfm_freq_meter u_meter (
    .i_ref_clk    (i_ref_clk),
    .i_rst        (i_rst),
    .i_raw_clk    (i_hdmi_clk),
    .i_pll_clk    (i_hdmi_pll_clk),
    .i_source_sel (cfg_q.measure_source_select),
    .i_gate_tick  (gate_tick_q),
    .o_meas       (meas)
  );

  // ------------------------------------------------------------
  // hysteresis and stability timer
  // ------------------------------------------------------------
  assign diff = (meas.mhz > stored_q) ? meas.mhz - stored_q : stored_q - meas.mhz;
  assign capture = meas.done && (diff > {5'h00, cfg_q.measure_hysteresis_mhz});

  always_comb begin
    case (cfg_q.stability_time_select)
      2'h0:    stbl_target = 12'(icfm_pkg::STBL_TIME_0_US / icfm_pkg::GATE_TIME_US);
      2'h1:    stbl_target = 12'(icfm_pkg::STBL_TIME_1_US / icfm_pkg::GATE_TIME_US);
      2'h2:    stbl_target = 12'(icfm_pkg::STBL_TIME_2_US / icfm_pkg::GATE_TIME_US);
      default: stbl_target = 12'(icfm_pkg::STBL_TIME_3_US / icfm_pkg::GATE_TIME_US);
    endcase
  end

  always_comb begin
    state_d    = state_q;
    stored_d   = stored_q;
    stbl_cnt_d = stbl_cnt_q;
    if (capture) begin
      stored_d = meas.mhz;
    end
    case (state_q)
      icfm_pkg::ST_IDLE: begin
        if (meas.done) begin
          state_d    = icfm_pkg::ST_SETTLING;
          stbl_cnt_d = 12'h000;
        end
      end
      icfm_pkg::ST_SETTLING: begin
        if (capture) begin
          stbl_cnt_d = 12'h000;
        end else if (meas.done) begin
          stbl_cnt_d = stbl_cnt_q + 12'h001;
          if (stbl_cnt_q + 12'h001 >= stbl_target) begin
            state_d = icfm_pkg::ST_STABLE;
          end
        end
      end
      icfm_pkg::ST_STABLE: begin
        if (capture) begin
          state_d    = icfm_pkg::ST_SETTLING;
          stbl_cnt_d = 12'h000;
        end
      end
      default: state_d = icfm_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q    <= icfm_pkg::ST_IDLE;
      stored_q   <= icfm_pkg::RST_MEASURED_FREQ;
      stbl_cnt_q <= 12'h000;
      settled_q  <= 1'b0;
    end else begin
      state_q    <= state_d;
      stored_q   <= stored_d;
      stbl_cnt_q <= stbl_cnt_d;
      // registered copy of the stable state, so the flag leaves a flip-flop
      settled_q  <= (state_d == icfm_pkg::ST_STABLE);
    end
  end

  // ------------------------------------------------------------
  // limits, detect and resets
  // ------------------------------------------------------------
  // low limit compare
  assign too_low  = stored_q < {2'h0, cfg_q.low_freq_limit};
  assign too_high = stored_q > {1'b0, cfg_q.high_freq_limit};

  always_comb begin
    present_d = (state_q == icfm_pkg::ST_STABLE) && !too_low && !too_high;
    if (cfg_q.override_clock_present) begin
      present_d = 1'b1;
    end
    o_pll_reset_d = capture && cfg_q.pll_reset_on_change;
    o_phy_reset_d = (capture || i_mode_change) && !(cfg_q.phy_reset_policy && det_5v);
  end

  // ------------------------------------------------------------
  // registers and swap state
  // ------------------------------------------------------------
  always_comb begin
    cfg_d  = cfg_q;
    swap_d = swap_q;
    if (!cfg_q.inhibit_auto_swap) begin
      swap_d = i_swap_detected;
    end
    if (i_reg_wr_en) begin
      if (i_reg_addr == icfm_pkg::ADDR_LINK_SETUP) begin
        if (cfg_q.inhibit_auto_swap) begin
          swap_d = i_reg_wdata[icfm_pkg::BIT_LINK_SWAP_STATE];
        end
        cfg_d.pll_reset_on_change   = i_reg_wdata[icfm_pkg::BIT_PLL_RESET_ON_CHG];
        cfg_d.measure_source_select = i_reg_wdata[icfm_pkg::BIT_MEASURE_SRC_SEL];
      end else if (i_reg_addr == icfm_pkg::ADDR_LINK_CLK_OVR) begin
        cfg_d.inhibit_auto_swap      = i_reg_wdata[icfm_pkg::BIT_INHIBIT_AUTO_SWAP];
        cfg_d.override_link_ready    = i_reg_wdata[icfm_pkg::BIT_OVERRIDE_LINK_RDY];
        cfg_d.override_clock_present = i_reg_wdata[icfm_pkg::BIT_OVERRIDE_CLK_PRES];
        cfg_d.stability_time_select  = i_reg_wdata[icfm_pkg::POS_STBL_SEL +: 2];
        cfg_d.measure_hysteresis_mhz = i_reg_wdata[icfm_pkg::POS_HYST +: 3];
      end else if (i_reg_addr == icfm_pkg::ADDR_LOW_THRESH) begin
        cfg_d.phy_reset_policy = i_reg_wdata[icfm_pkg::BIT_PHY_RESET_POLICY];
        cfg_d.low_freq_limit   = i_reg_wdata[icfm_pkg::POS_LOW_LIMIT +: 6];
      end else if (i_reg_addr == icfm_pkg::ADDR_HIGH_THRESH) begin
        cfg_d.high_freq_limit = i_reg_wdata[icfm_pkg::POS_HIGH_LIMIT +: 7];
      end
    end
  end

  assign meas_read = rx_valid ? stored_q : 8'h00;

  // reads return the previous cycle's address; unmapped and reserved bits read zero
  always_comb begin
    rdata_d = 8'h00;
    if (i_reg_addr == icfm_pkg::ADDR_LINK_SETUP) begin
      rdata_d[icfm_pkg::BIT_LINK_SWAP_STATE]  = swap_q;
      rdata_d[icfm_pkg::BIT_PLL_RESET_ON_CHG] = cfg_q.pll_reset_on_change;
      rdata_d[icfm_pkg::BIT_MEASURE_SRC_SEL]  = cfg_q.measure_source_select;
    end else if (i_reg_addr == icfm_pkg::ADDR_LINK_CLK_OVR) begin
      rdata_d = {cfg_q.inhibit_auto_swap, cfg_q.override_link_ready, cfg_q.override_clock_present,
                 cfg_q.stability_time_select, cfg_q.measure_hysteresis_mhz};
    end else if (i_reg_addr == icfm_pkg::ADDR_LOW_THRESH) begin
      rdata_d = {1'b0, cfg_q.phy_reset_policy, cfg_q.low_freq_limit};
    end else if (i_reg_addr == icfm_pkg::ADDR_HIGH_THRESH) begin
      rdata_d = {1'b0, cfg_q.high_freq_limit};
    end else if (i_reg_addr == icfm_pkg::ADDR_MEASURED_FREQ) begin
      rdata_d = meas_read;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      cfg_q <= '{inhibit_auto_swap:      icfm_pkg::RST_INHIBIT_SWAP,
                 override_link_ready:    icfm_pkg::RST_OVERRIDE_LINK,
                 override_clock_present: icfm_pkg::RST_OVERRIDE_CLK,
                 stability_time_select:  icfm_pkg::RST_STBL_SEL,
                 measure_hysteresis_mhz: icfm_pkg::RST_HYST_MHZ,
                 phy_reset_policy:       icfm_pkg::RST_PHY_POLICY,
                 low_freq_limit:         icfm_pkg::RST_LOW_LIMIT,
                 high_freq_limit:        icfm_pkg::RST_HIGH_LIMIT,
                 pll_reset_on_change:    icfm_pkg::RST_PLL_RESET_ON_CHG,
                 measure_source_select:  icfm_pkg::RST_MEASURE_SRC_SEL};
      swap_q            <= icfm_pkg::RST_LINK_SWAP_STATE;
      o_reg_rdata_q     <= 8'h00;
      o_clock_present_q <= 1'b0;
      o_freq_too_low_q  <= 1'b0;
      o_freq_too_high_q <= 1'b0;
      o_link_ready_q    <= 1'b0;
      o_pll_reset_q     <= 1'b0;
      o_phy_reset_q     <= 1'b0;
    end else begin
      cfg_q             <= cfg_d;
      swap_q            <= swap_d;
      o_reg_rdata_q     <= rdata_d;
      o_clock_present_q <= present_d;
      o_freq_too_low_q  <= too_low;
      o_freq_too_high_q <= too_high;
      o_link_ready_q    <= bc_link_ok || cfg_q.override_link_ready;
      o_pll_reset_q     <= o_pll_reset_d;
      o_phy_reset_q     <= o_phy_reset_d;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign o_reg_rdata       = o_reg_rdata_q;
  assign o_clock_present   = o_clock_present_q;
  assign o_freq_too_low    = o_freq_too_low_q;
  assign o_freq_too_high   = o_freq_too_high_q;
  assign o_freq_settled    = settled_q;
  assign o_link_ready      = o_link_ready_q;
  assign o_link_swap_state = swap_q;
  assign o_pll_reset       = o_pll_reset_q;
  assign o_phy_reset       = o_phy_reset_q;

endmodule

// >>> bench/icfm_hdmi_source_model.sv
// model: source of the measured clock and of its pll copy at twice the rate
module icfm_hdmi_source_model (
  // frequency request in mhz, zero stops both clocks
  input  wire logic [7:0] i_mhz,
  // generated clocks
  output logic            o_hdmi_clk,
  output logic            o_pll_clk
);
  timeunit 1ns;
  timeprecision 1ps;

  // a stopped source parks its clock low instead of leaving the last level
  always begin
    if (i_mhz == 8'h00) begin
      o_hdmi_clk = 1'b0;
      @(i_mhz);
    end else begin
      #(500.0 / i_mhz);
      o_hdmi_clk = ~o_hdmi_clk;
    end
  end

  always begin
    if (i_mhz == 8'h00) begin
      o_pll_clk = 1'b0;
      @(i_mhz);
    end else begin
      #(250.0 / i_mhz);
      o_pll_clk = ~o_pll_clk;
    end
  end
endmodule

// >>> bench/icfm_top_assertions.sv
// checker: port-level properties of the clock frequency monitor
module icfm_top_assertions (
  // clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst,
  // register port and events
  input  wire logic [7:0] i_reg_addr,
  input  wire logic       i_reg_wr_en,
  input  wire logic [7:0] i_reg_wdata,
  input  wire logic       i_mode_change,
  input  wire logic       i_swap_detected,
  // watched outputs
  input  wire logic       o_clock_present,
  input  wire logic       o_freq_settled,
  input  wire logic       o_link_ready,
  input  wire logic       o_link_swap_state,
  input  wire logic       o_pll_reset,
  input  wire logic       o_phy_reset
);
  logic [7:0] setup_q;
  logic [7:0] ovr_q;
  logic [7:0] low_q;
  logic       setup_wr;

  // ----------------------------------------------------------
  // shadow of the written configuration
  // ----------------------------------------------------------
  assign setup_wr = i_reg_wr_en && (i_reg_addr == icfm_pkg::ADDR_LINK_SETUP);
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      setup_q <= 8'h20;
      ovr_q   <= 8'h02;
      low_q   <= 8'h06;
    end else begin
      if (setup_wr) setup_q <= i_reg_wdata;
      if (i_reg_wr_en && i_reg_addr == icfm_pkg::ADDR_LINK_CLK_OVR) ovr_q <= i_reg_wdata;
      if (i_reg_wr_en && i_reg_addr == icfm_pkg::ADDR_LOW_THRESH) low_q <= i_reg_wdata;
    end
  end

  // ----------------------------------------------------------
  // properties
  // ----------------------------------------------------------
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  sequence mode_req;
    i_mode_change && !low_q[6];
  endsequence

  link_ready_a: assert property (ovr_q[6] |=> o_link_ready)
    else $error("link ready not forced");
  clock_present_a: assert property (ovr_q[5] |=> o_clock_present)
    else $error("clock present not forced");
  // the pulse reflects the enable of the cycle in which the capture was seen
  pll_enable_a: assert property (o_pll_reset |-> $past(setup_q[5]))
    else $error("pll reset while disabled");
  pll_pulse_a: assert property (o_pll_reset |=> !o_pll_reset)
    else $error("pll reset longer than one cycle");
  mode_phy_a: assert property (mode_req |=> o_phy_reset)
    else $error("mode change gave no phy reset");
  settle_drop_a: assert property (o_pll_reset |=> !o_freq_settled)
    else $error("settled kept after capture");
  swap_follow_a: assert property (!ovr_q[7] |=> (o_link_swap_state == $past(i_swap_detected)))
    else $error("swap state not following detector");
  swap_hold_a: assert property (ovr_q[7] && !setup_wr |=> $stable(o_link_swap_state))
    else $error("swap state moved while inhibited");
endmodule

bind icfm_top icfm_top_assertions u_icfm_top_assertions (
  .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_reg_addr(i_reg_addr), .i_reg_wr_en(i_reg_wr_en),
  .i_reg_wdata(i_reg_wdata), .i_mode_change(i_mode_change), .i_swap_detected(i_swap_detected),
  .o_clock_present(o_clock_present), .o_freq_settled(o_freq_settled), .o_link_ready(o_link_ready),
  .o_link_swap_state(o_link_swap_state), .o_pll_reset(o_pll_reset), .o_phy_reset(o_phy_reset)
);

// >>> bench/icfm_top_tb.sv
// testbench: register and measurement scenarios of the clock frequency monitor
module icfm_top_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic       i_ref_clk = 1'b0;
  logic       i_rst, i_reg_wr_en, i_hdmi_5v_det, i_rx_signal_valid, i_backchannel_link_ok;
  logic       i_mode_change, i_swap_detected, hdmi_clk, pll_clk;
  logic       o_clock_present, o_freq_too_low, o_freq_too_high, o_freq_settled;
  logic       o_link_ready, o_link_swap_state, o_pll_reset, o_phy_reset;
  logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, v;
  logic [7:0] src_mhz = 8'h00;
  int         err_count = 0;
  int         checks = 0;
  int         pll_cnt = 0;
  int         phy_cnt = 0;
  int         n, p, q;

  always #5 i_ref_clk = ~i_ref_clk;

  icfm_top u_icfm_top (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_reg_addr(i_reg_addr), .i_reg_wr_en(i_reg_wr_en),
    .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .i_hdmi_clk(hdmi_clk), .i_hdmi_pll_clk(pll_clk),
    .i_hdmi_5v_det(i_hdmi_5v_det), .i_rx_signal_valid(i_rx_signal_valid),
    .i_backchannel_link_ok(i_backchannel_link_ok), .i_mode_change(i_mode_change),
    .i_swap_detected(i_swap_detected), .o_clock_present(o_clock_present), .o_freq_too_low(o_freq_too_low),
    .o_freq_too_high(o_freq_too_high), .o_freq_settled(o_freq_settled), .o_link_ready(o_link_ready),
    .o_link_swap_state(o_link_swap_state), .o_pll_reset(o_pll_reset), .o_phy_reset(o_phy_reset)
  );

  icfm_hdmi_source_model u_icfm_hdmi_source_model (.i_mhz(src_mhz), .o_hdmi_clk(hdmi_clk), .o_pll_clk(pll_clk));

  // counted off the falling edge, half a cycle after the rising edge that launches the pulse, so it is settled when seen
  always @(negedge i_ref_clk) begin
    if (o_pll_reset === 1'b1) pll_cnt++;
    if (o_phy_reset === 1'b1) phy_cnt++;
  end

  // ----------------------------------------------------------
  // access and checking tasks
  // ----------------------------------------------------------
  task automatic complete_run();
    if (err_count == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge i_ref_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_ref_clk);
    i_reg_addr  = a;
    i_reg_wdata = d;
    i_reg_wr_en = 1'b1;
    @(negedge i_ref_clk);
    i_reg_wr_en = 1'b0;
  endtask

  // read data trails the address by one edge
  task automatic rd(input logic [7:0] a);
    @(negedge i_ref_clk);
    i_reg_addr = a;
    @(negedge i_ref_clk);
    v = o_reg_rdata;
  endtask

  // edge counting over an unaligned gate may land one step either side
  function automatic logic [7:0] near(input logic [7:0] x, input logic [7:0] e);
    return 8'(x >= e - 8'h01 && x <= e + 8'h01);
  endfunction

  task automatic wait_pll(input int lim);
    int p0;
    p0 = pll_cnt;
    for (n = 0; n < lim && pll_cnt == p0; n++) cyc(1);
    if (pll_cnt == p0) begin
      check(8'h00, 8'h01);
      complete_run();
    end
  endtask

  task automatic pulse_mode();
    @(negedge i_ref_clk);
    i_mode_change = 1'b1;
    @(negedge i_ref_clk);
    i_mode_change = 1'b0;
  endtask

  // ----------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------
  initial begin
    logic [7:0] addrs [6];
    logic [7:0] dflts [6];
    addrs = '{8'h5b, 8'h5c, 8'h5d, 8'h5e, 8'h5f, 8'h60};
    dflts = '{8'h20, 8'h02, 8'h06, 8'h2c, 8'h00, 8'h00};
    {i_rst, i_reg_wr_en, i_hdmi_5v_det, i_rx_signal_valid} = 4'h8;
    {i_backchannel_link_ok, i_mode_change, i_swap_detected} = 3'h0;
    i_reg_addr  = 8'h00;
    i_reg_wdata = 8'h00;
    cyc(5);
    i_rst = 1'b0;
    foreach (addrs[i]) begin
      rd(addrs[i]);
      check(v, dflts[i]);
    end
    wr(8'h5f, 8'hab);
    rd(8'h5f);
    check(v, 8'h00);
    wr(8'h5d, 8'h48);
    rd(8'h5d);
    check(v, 8'h48);
    wr(8'h5d, 8'h06);
    i_backchannel_link_ok = 1'b1;
    cyc(4);
    check(o_link_ready, 8'h01);
    i_backchannel_link_ok = 1'b0;
    cyc(4);
    check(o_link_ready, 8'h00);
    wr(8'h5c, 8'h42);
    cyc(2);
    check(o_link_ready, 8'h01);
    wr(8'h5c, 8'h22);
    cyc(2);
    check(o_clock_present, 8'h01);
    wr(8'h5c, 8'h02);
    cyc(2);
    check({o_clock_present, o_link_ready}, 8'h00);
    i_swap_detected = 1'b1;
    wr(8'h5b, 8'h20);
    cyc(1);
    check(o_link_swap_state, 8'h01);
    wr(8'h5c, 8'h82);
    wr(8'h5b, 8'h20);
    cyc(2);
    check(o_link_swap_state, 8'h00);
    wr(8'h5b, 8'h60);
    i_swap_detected = 1'b0;
    cyc(2);
    check(o_link_swap_state, 8'h01);
    wr(8'h5c, 8'h02);
    cyc(2);
    check(o_link_swap_state, 8'h00);
    q = phy_cnt;
    pulse_mode();
    cyc(1);
    check(8'(phy_cnt - q), 8'h01);
    wr(8'h5d, 8'h46);
    i_hdmi_5v_det = 1'b1;
    cyc(3);
    q = phy_cnt;
    pulse_mode();
    cyc(2);
    check(8'(phy_cnt - q), 8'h00);
    i_rx_signal_valid = 1'b1;
    src_mhz = 8'd20;
    wait_pll(300);
    for (n = 0; n < 16500 && o_freq_settled !== 1'b1; n++) cyc(1);
    check(8'(n >= 15800 && n <= 16200), 8'h01);
    if (n == 16500) complete_run();
    cyc(2);
    check({o_clock_present, o_freq_too_low, o_freq_too_high}, 8'h04);
    check(8'(phy_cnt - q), 8'h00);
    rd(8'h5f);
    check(near(v, 8'd20), 8'h01);
    wr(8'h5d, 8'h5e);
    cyc(3);
    check({o_freq_too_low, o_clock_present}, 8'h02);
    wr(8'h5d, 8'h46);
    wr(8'h5e, 8'h0a);
    cyc(3);
    check(o_freq_too_high, 8'h01);
    wr(8'h5e, 8'h2c);
    i_rx_signal_valid = 1'b0;
    cyc(4);
    rd(8'h5f);
    check(v, 8'h00);
    i_rx_signal_valid = 1'b1;
    wr(8'h5c, 8'h07);
    p = pll_cnt;
    src_mhz = 8'd25;
    cyc(400);
    check({7'(pll_cnt - p), o_freq_settled}, 8'h01);
    wr(8'h5c, 8'h02);
    wait_pll(300);
    cyc(2);
    check(o_freq_settled, 8'h00);
    rd(8'h5f);
    check(near(v, 8'd25), 8'h01);
    src_mhz = 8'd20;
    wr(8'h5b, 8'h30);
    cyc(400);
    rd(8'h5f);
    check(near(v, 8'd40), 8'h01);
    p = pll_cnt;
    wr(8'h5b, 8'h00);
    cyc(400);
    check(8'(pll_cnt - p), 8'h00);
    check(8'(phy_cnt - q), 8'h00);
    rd(8'h5f);
    check(near(v, 8'd20), 8'h01);
    wr(8'h5d, 8'h06);
    src_mhz = 8'd30;
    cyc(400);
    check(8'(phy_cnt != q), 8'h01);
    // second stability code: 640 quiet gates after the last capture
    wr(8'h5b, 8'h20);
    wr(8'h5c, 8'h0a);
    src_mhz = 8'd20;
    wait_pll(300);
    for (n = 0; n < 66000 && o_freq_settled !== 1'b1; n++) cyc(1);
    check(8'(n >= 63800 && n <= 64200), 8'h01);
    if (n == 66000) complete_run();
    cyc(2);
    check(o_clock_present, 8'h01);
    complete_run();
  end
endmodule
